// ---- eda_ext_access.sv ----
`timescale 1ns/10ps
module eda_ext_access #(
    parameter int NORMAL_MC_MAX = eda_pkg::MC_MAX_NORMAL
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    input  wire logic        i_op_valid,
    input  wire logic        i_op_external_data_move,
    input  wire logic        i_op_ptr_form,
    input  wire logic        i_op_write,
    input  wire logic [2:0]  i_op_cycles,
    input  wire logic [7:0]  i_op_wdata,
    input  wire logic [7:0]  i_index_reg,
    input  wire logic [7:0]  i_port2_latch,
    input  wire logic [7:0]  i_ext_rdata,
    output logic [15:0]      o_ext_addr,
    output logic [7:0]       o_ext_wdata,
    output logic             o_rd_n,
    output logic             o_wr_n,
    output logic             o_fetch,
    output logic             o_busy,
    output logic             o_done,
    output logic [7:0]       o_op_rdata,
    output logic [1:0]       o_state
);
    import eda_pkg::*;

    generate
        if (NORMAL_MC_MAX < 1 || NORMAL_MC_MAX > 7) begin : g_bad_param
            $error("NORMAL_MC_MAX must lie in 1..7");
        end
    endgenerate

    logic [1:0]     phase;
    logic [1:0]     phase_nx;
    eda_state_t     state_reg;
    eda_state_t     state_next;
    logic [3:0]     mc_reg;
    logic [3:0]     mc_next;
    logic [3:0]     last_reg;
    logic           external_data_move_reg;
    logic           ptr_form_reg;
    logic           write_reg;
    logic [2:0]     stretch_reg;
    logic [2:0]     cycles_reg;
    logic [15:0]    dp0_reg;
    logic [15:0]    dp1_reg;
    logic           sel_reg;
    logic [2:0]     timing_reg;
    logic [7:0]     rdata_reg;
    logic [15:0]    addr_reg;
    logic [7:0]     wdata_reg;
    logic           rd_n_reg;
    logic           wr_n_reg;
    logic           fetch_reg;
    logic           busy_reg;
    logic           done_reg;
    logic [7:0]     op_rdata_reg;
    logic [7:0]     neg_sample_reg;

    eda_cycle_seq u_seq (
        .i_clk        (i_clk),
        .i_resetn     (i_resetn),
        .o_phase      (phase),
        .o_phase_next (phase_nx)
    );

    // Register port decode
    wire wr_dp0_lo   = i_wr && (i_addr == OFS_DP0_LO);
    wire wr_dp0_hi   = i_wr && (i_addr == OFS_DP0_HI);
    wire wr_dp1_lo   = i_wr && (i_addr == OFS_DP1_LO);
    wire wr_dp1_hi   = i_wr && (i_addr == OFS_DP1_HI);
    wire wr_sel      = i_wr && (i_addr == OFS_PTR_SELECT);
    wire wr_timing   = i_wr && (i_addr == OFS_BUS_TIMING);

    function automatic logic [7:0] read_mux(input logic [7:0] a);
        case (a)
            OFS_DP0_LO:     read_mux = dp0_reg[7:0];
            OFS_DP0_HI:     read_mux = dp0_reg[15:8];
            OFS_DP1_LO:     read_mux = dp1_reg[7:0];
            OFS_DP1_HI:     read_mux = dp1_reg[15:8];
            OFS_PTR_SELECT: read_mux = {7'h00, sel_reg};
            OFS_BUS_TIMING: read_mux = {5'h00, timing_reg};
            OFS_STATUS:     read_mux = {busy_reg, external_data_move_reg, write_reg, 3'h0, phase};
            default:        read_mux = 8'h00;
        endcase
    endfunction : read_mux

    wire [7:0]  rd_value   = read_mux(i_addr);
    wire [15:0] active_dp  = sel_reg ? dp1_reg : dp0_reg;
    // Address source for the access cycle
    wire [15:0] addr_src   = ptr_form_reg ? active_dp : {i_port2_latch, i_index_reg};

    // Instruction sequencing at machine-cycle boundaries
    wire        mc_end     = (phase == PH_FOUR);
    wire        at_last    = (state_reg != ST_IDLE) && (mc_reg == last_reg);
    wire        take_op    = mc_end && i_op_valid && ((state_reg == ST_IDLE) || at_last);
    wire [2:0]  cyc_clamp  = (i_op_cycles == 3'h0) ? 3'h1 :
                             (i_op_cycles > 3'(NORMAL_MC_MAX)) ? 3'(NORMAL_MC_MAX) : i_op_cycles;
    wire [3:0]  last_new   = i_op_external_data_move ? ({1'b0, timing_reg} + 4'h1) : ({1'b0, cyc_clamp} - 4'h1);
    wire        enter_acc  = mc_end && (state_reg == ST_FETCH) && external_data_move_reg && !at_last;

    always_comb begin
        state_next = state_reg;
        mc_next    = mc_reg;
        if (mc_end) begin
            if (take_op) begin
                state_next = ST_FETCH;
                mc_next    = 4'h0;
            end else if ((state_reg == ST_IDLE) || at_last) begin
                state_next = ST_IDLE;
                mc_next    = 4'h0;
            end else begin
                state_next = external_data_move_reg ? ST_ACCESS : ST_EXEC;
                mc_next    = mc_reg + 4'h1;
            end
        end
    end

    // Strobe placement for the cycle about to start
    wire [3:0]  acc_idx    = mc_next - 4'h1;
    wire        in_acc_nx  = (state_next == ST_ACCESS);
    wire        strb_s0    = (acc_idx == 4'h0) && ((phase_nx == PH_TWO) || (phase_nx == PH_THREE));
    wire        strb_first = (acc_idx == 4'h0) && (phase_nx >= PH_THREE);
    wire        strb_mid   = (acc_idx != 4'h0) && (acc_idx < {1'b0, stretch_reg});
    wire        strb_last  = (acc_idx == {1'b0, stretch_reg}) && (phase_nx <= PH_TWO);
    // Widening keeps the strobe centred on the access; width is 2 clocks, else 4 per stretch step
    wire        strobe_nx  = in_acc_nx && ((stretch_reg == 3'h0) ? strb_s0
                                          : (strb_first || strb_mid || strb_last));
    wire        fetch_nx   = (phase_nx == PH_ONE) && ((state_next == ST_FETCH) || (state_next == ST_EXEC));

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_IDLE;
            mc_reg    <= 4'h0;
        end else begin
            state_reg <= state_next;
            mc_reg    <= mc_next;
        end
    end

    // Operation attributes are frozen at acceptance so a mid-move bus timing write cannot disturb it; pointer and select writes still apply until access entry
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            last_reg     <= 4'h0;
            external_data_move_reg     <= 1'b0;
            ptr_form_reg <= 1'b0;
            write_reg    <= 1'b0;
            stretch_reg  <= STRETCH_RESET;
            cycles_reg   <= 3'h1;
            wdata_reg    <= 8'h00;
        end else if (take_op) begin
            last_reg     <= last_new;
            external_data_move_reg     <= i_op_external_data_move;
            ptr_form_reg <= i_op_ptr_form;
            write_reg    <= i_op_write;
            stretch_reg  <= timing_reg;
            cycles_reg   <= cyc_clamp;
            wdata_reg    <= i_op_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dp0_reg    <= DP_RESET;
            dp1_reg    <= DP_RESET;
            sel_reg    <= SEL_RESET;
            timing_reg <= STRETCH_RESET;
        end else begin
            if (wr_dp0_lo) dp0_reg[7:0]  <= i_wdata;
            if (wr_dp0_hi) dp0_reg[15:8] <= i_wdata;
            if (wr_dp1_lo) dp1_reg[7:0]  <= i_wdata;
            if (wr_dp1_hi) dp1_reg[15:8] <= i_wdata;
            // Only bit 0 is stored, so a read-add-write of this register flips the pointer
            if (wr_sel) sel_reg <= i_wdata[SEL_BIT_POS];
            if (wr_timing) timing_reg <= i_wdata[STRETCH_LSB +: STRETCH_W];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= i_rd ? rd_value : 8'h00;
        end
    end

    // Address loads once at access entry and is then held until the next move
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            addr_reg <= 16'h0000;
        end else if (enter_acc) begin
            addr_reg <= addr_src;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_n_reg  <= 1'b1;
            wr_n_reg  <= 1'b1;
            fetch_reg <= 1'b0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            rd_n_reg  <= !(strobe_nx && !write_reg);
            wr_n_reg  <= !(strobe_nx && write_reg);
            fetch_reg <= fetch_nx;
            busy_reg  <= (state_next != ST_IDLE);
            done_reg  <= mc_end && at_last;
        end
    end

    // Read data is caught on the falling edge, mid-clock, while the strobe is still low
    always_ff @(negedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            neg_sample_reg <= 8'h00;
        end else if (!rd_n_reg) begin
            neg_sample_reg <= i_ext_rdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            op_rdata_reg <= 8'h00;
        end else if (mc_end && at_last && external_data_move_reg && !write_reg) begin
            op_rdata_reg <= neg_sample_reg;
        end
    end

    assign o_rdata     = rdata_reg;
    assign o_ext_addr  = addr_reg;
    assign o_ext_wdata = wdata_reg;
    assign o_rd_n      = rd_n_reg;
    assign o_wr_n      = wr_n_reg;
    assign o_fetch     = fetch_reg;
    assign o_busy      = busy_reg;
    assign o_done      = done_reg;
    assign o_op_rdata  = op_rdata_reg;
    assign o_state     = phase;

    // Helper counters for the checks below
    logic [6:0] h_clk_cnt;
    logic [5:0] h_strb_cnt;
    wire        strobe_act = !rd_n_reg || !wr_n_reg;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            h_clk_cnt  <= 7'h00;
            h_strb_cnt <= 6'h00;
        end else begin
            h_clk_cnt  <= take_op ? 7'h01 : h_clk_cnt + 7'h01;
            h_strb_cnt <= strobe_act ? h_strb_cnt + 6'h01 : 6'h00;
        end
    end

    chk_external_data_move_length: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (mc_end && at_last && external_data_move_reg) |-> (h_clk_cnt == 7'(CLKS_PER_MC * (stretch_reg + EXTERNAL_DATA_MOVE_BASE_MC))))
        else $error("external move length differs from stretch plus two");

    chk_normal_len: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (mc_end && at_last && !external_data_move_reg) |-> (h_clk_cnt == 7'(CLKS_PER_MC * cycles_reg)))
        else $error("normal instruction length changed");

    chk_strobe_width: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(strobe_act) |-> (h_strb_cnt == ((stretch_reg == 3'h0) ? 6'h02 : 6'(CLKS_PER_MC * stretch_reg))))
        else $error("strobe width does not match stretch");

    chk_addr_stable: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (strobe_act && $past(strobe_act)) |-> $stable(addr_reg))
        else $error("address moved during strobe");

    chk_addr_source: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (enter_acc && ptr_form_reg) |=> (addr_reg == (sel_reg ? dp1_reg : dp0_reg)))
        else $error("pointer form address not from selected pointer");

    chk_index_addr: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (enter_acc && !ptr_form_reg) |=> (addr_reg == {$past(i_port2_latch), $past(i_index_reg)}))
        else $error("index form address wrong");

    chk_sel_upper: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_rd && (i_addr == OFS_PTR_SELECT)) |=> (rdata_reg[7:1] == 7'h00))
        else $error("select register upper bits not zero");

    chk_no_strobe_fetch: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (state_reg == ST_FETCH) |-> !strobe_act)
        else $error("strobe during opcode fetch");

    chk_fetch_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
        fetch_reg |-> (phase == PH_ONE) ##1 !fetch_reg [*3])
        else $error("more than one fetch per machine cycle");

    chk_done_single: assert property (@(posedge i_clk) disable iff (!i_resetn)
        done_reg |=> !done_reg)
        else $error("done pulse longer than one clock");

    chk_strobe_excl: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !(!rd_n_reg && !wr_n_reg))
        else $error("read and write strobes low together");
endmodule : eda_ext_access

// ---- eda_pkg.sv ----
// Summary of operation
// - Every machine cycle is four clocks, states one to four in fixed order.
// - Internal timing uses both clock edges within a state.
// - One opcode byte fetched per machine cycle; cycles track instruction bytes. The code fetches no byte in the access cycles of an external move.
// - Other instructions last one to five machine cycles: five duration classes.
// - External data move lasts from two to nine machine cycles.
// - Read and write strobes widen with the added machine cycles.
// - Index form: address low from index register, high from port 2 latch.
// - Pointer form: all sixteen address bits from the selected data pointer.
// - Select bit 0 picks data pointer zero, 1 picks data pointer one.
// - Upper seven select register bits do nothing and read zero.
// - Incrementing or decrementing the select register toggles the pointer.
// - Move starts with a normal fetch; access happens in the following cycle.
// - Stretch field bits 2..0 give move length of stretch plus two cycles.
// - Stretch lengthens only the external move; other timing unchanged.
// - Stretch resets to 1 (three cycles); writing 0 gives two cycles.
package eda_pkg;
    localparam logic [7:0] OFS_DP0_LO      = 8'h82;
    localparam logic [7:0] OFS_DP0_HI      = 8'h83;
    localparam logic [7:0] OFS_DP1_LO      = 8'h84;
    localparam logic [7:0] OFS_DP1_HI      = 8'h85;
    localparam logic [7:0] OFS_PTR_SELECT  = 8'h86;
    localparam logic [7:0] OFS_BUS_TIMING  = 8'h8e;
    localparam logic [7:0] OFS_STATUS      = 8'h8f;
    localparam int         SEL_BIT_POS     = 0;
    localparam int         STRETCH_LSB     = 0;
    localparam int         STRETCH_W       = 3;
    localparam logic [2:0] STRETCH_RESET   = 3'h1;
    localparam logic       SEL_RESET       = 1'b0;
    localparam logic [15:0] DP_RESET       = 16'h0000;
    localparam int         CLKS_PER_MC     = 4;
    localparam int         MC_MAX_NORMAL   = 5;
    localparam int         EXTERNAL_DATA_MOVE_BASE_MC    = 2;
    localparam logic [1:0] PH_ONE          = 2'h0;
    localparam logic [1:0] PH_TWO          = 2'h1;
    localparam logic [1:0] PH_THREE        = 2'h2;
    localparam logic [1:0] PH_FOUR         = 2'h3;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_ACCESS} eda_state_t;
endpackage : eda_pkg

// ---- eda_cycle_seq.sv ----
`timescale 1ns/10ps
module eda_cycle_seq (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    output logic [1:0]      o_phase,
    output logic [1:0]      o_phase_next
);
    import eda_pkg::*;

    logic [1:0] phase_reg;

    assign o_phase_next = phase_reg + 2'h1;
    assign o_phase      = phase_reg;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_reg <= PH_ONE;
        end else begin
            phase_reg <= o_phase_next;
        end
    end

    chk_phase_order: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_reg == PH_FOUR) |=> (phase_reg == PH_ONE) ##1 (phase_reg == PH_TWO) ##1 (phase_reg == PH_THREE))
        else $error("machine cycle states out of order");
endmodule : eda_cycle_seq

// ---- eda_ext_mem.sv ----
`timescale 1ns/10ps
module eda_ext_mem (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    output logic [7:0]       o_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    // Every place starts as a pattern of its address, so a wrong address shows up as wrong data unless its two bytes have the same XOR
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
        end
    end

    // Released bus shows the inverse of the last value, never a stale copy
    assign o_rdata = i_rd_n ? ~last_q : mem[i_addr];

    always @(negedge i_clk) begin
        if (!i_rd_n) last_q <= mem[i_addr];
    end

    always @(posedge i_clk) begin
        if (!i_wr_n) mem[i_addr] <= i_wdata;
    end
endmodule : eda_ext_mem

// ---- test_ext_data_access_stretch.sv ----
`timescale 1ns/10ps
module test_ext_data_access_stretch;
    import eda_pkg::*;
    logic        i_clk, i_resetn, i_wr, i_rd, i_op_valid, i_op_external_data_move, i_op_ptr_form, i_op_write;
    logic [7:0]  i_addr, i_wdata, i_op_wdata, i_index_reg, i_port2_latch;
    logic [2:0]  i_op_cycles;
    logic [7:0]  o_rdata, ext_rdata, o_ext_wdata, o_op_rdata, got_data;
    logic [15:0] o_ext_addr, got_addr;
    logic        o_rd_n, o_wr_n, o_fetch, o_busy, o_done, addr_moved;
    logic [1:0]  o_state;
    int          n_mismatch = 0;
    int          checked = 0;
    int          n_cycle = 0;
    int          n_clk, n_strobe, n_fetch, n_busy;

    eda_ext_access dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_op_valid(i_op_valid), .i_op_external_data_move(i_op_external_data_move),
        .i_op_ptr_form(i_op_ptr_form), .i_op_write(i_op_write), .i_op_cycles(i_op_cycles),
        .i_op_wdata(i_op_wdata), .i_index_reg(i_index_reg), .i_port2_latch(i_port2_latch),
        .i_ext_rdata(ext_rdata), .o_ext_addr(o_ext_addr), .o_ext_wdata(o_ext_wdata), .o_rd_n(o_rd_n),
        .o_wr_n(o_wr_n), .o_fetch(o_fetch), .o_busy(o_busy), .o_done(o_done), .o_op_rdata(o_op_rdata),
        .o_state(o_state));

    eda_ext_mem mem (.i_clk(i_clk), .i_addr(o_ext_addr), .i_wdata(o_ext_wdata), .i_rd_n(o_rd_n),
        .i_wr_n(o_wr_n), .o_rdata(ext_rdata));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic conclude();
        $display("Counts: %0d mismatches in %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_cnt(input int got, input int exp, input string m);
        checked++;
        if (got != exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %0d expected %0d", $time, m, got, exp);
        end
    endtask : cmp_cnt

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input string m);
        @(posedge i_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        cmp_val({8'h00, o_rdata}, {8'h00, e}, m);
    endtask : reg_rd

    // Request is raised so that it is seen at a state-four edge, then counted to completion
    task automatic run_op(input logic mv, input logic pf, input logic wr, input logic [2:0] cy,
                          input logic [7:0] wd);
        logic [1:0] prev;
        logic       bad;
        n_clk = 0;
        n_strobe = 0;
        n_fetch = 0;
        n_busy = 0;
        addr_moved = 1'b0;
        bad = 1'b0;
        do @(negedge i_clk); while (o_state !== PH_THREE);
        @(posedge i_clk);
        {i_op_valid, i_op_external_data_move, i_op_ptr_form, i_op_write, i_op_cycles, i_op_wdata} <= {1'b1, mv, pf, wr, cy, wd};
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        prev = PH_FOUR;
        do begin
            @(negedge i_clk);
            n_clk++;
            bad |= (o_state !== prev + 2'h1);
            prev = o_state;
            if (o_fetch === 1'b1) n_fetch++;
            if (o_busy === 1'b1) n_busy++;
            if (o_rd_n === 1'b0 || o_wr_n === 1'b0) begin
                if (n_strobe == 0) got_addr = o_ext_addr;
                addr_moved |= (o_ext_addr !== got_addr);
                n_strobe++;
            end
        end while (o_done !== 1'b1 && n_clk < 200);
        got_data = o_op_rdata;
        cmp_cnt(int'(bad), 0, "state order");
        cmp_cnt(n_busy, n_clk - 1, "busy span");
    endtask : run_op

    task automatic t_regs();
        reg_rd(OFS_BUS_TIMING, 8'h01, "stretch after reset");
        reg_rd(OFS_PTR_SELECT, 8'h00, "select after reset");
        reg_wr(OFS_PTR_SELECT, 8'hff);
        reg_rd(OFS_PTR_SELECT, 8'h01, "select upper bits");
        reg_wr(OFS_PTR_SELECT, 8'h02);
        reg_rd(OFS_PTR_SELECT, 8'h00, "select after increment");
        reg_wr(8'h90, 8'hff);
        reg_rd(8'h90, 8'h00, "unmapped place");
    endtask : t_regs

    task automatic t_stretch();
        logic [7:0] exp_mem;
        exp_mem = 8'h34 ^ 8'h12 ^ 8'h5a;
        reg_wr(OFS_DP0_LO, 8'h34);
        reg_wr(OFS_DP0_HI, 8'h12);
        run_op(1'b1, 1'b1, 1'b0, 3'h0, 8'h00);
        cmp_cnt(n_clk, 13, "default move length");
        cmp_cnt(n_strobe, 4, "default strobe width");
        for (int s = 0; s < 8; s++) begin
            reg_wr(OFS_BUS_TIMING, 8'hf8 | 8'(s));
            reg_rd(OFS_BUS_TIMING, 8'(s), "stretch field");
            run_op(1'b1, 1'b1, s[0], 3'h0, 8'ha0 + 8'(s));
            cmp_cnt(n_clk, 4 * (s + 2) + 1, "move length");
            cmp_cnt(n_strobe, (s == 0) ? 2 : 4 * s, "strobe width");
            cmp_cnt(n_fetch, 1, "fetch before access");
            cmp_cnt(int'(addr_moved), 0, "address moved in strobe");
            cmp_val(got_addr, 16'h1234, "pointer address");
            if (s[0]) exp_mem = 8'ha0 + 8'(s);
            else cmp_val({8'h00, got_data}, {8'h00, exp_mem}, "read data");
        end
    endtask : t_stretch

    task automatic t_normal();
        for (int c = 1; c <= MC_MAX_NORMAL; c++) begin
            run_op(1'b0, 1'b0, 1'b0, 3'(c), 8'h00);
            cmp_cnt(n_clk, 4 * c + 1, "instruction length");
            cmp_cnt(n_fetch, c, "fetch count");
            cmp_cnt(n_strobe, 0, "strobe outside move");
        end
    endtask : t_normal

    task automatic t_select();
        reg_wr(OFS_DP1_LO, 8'hef);
        reg_wr(OFS_DP1_HI, 8'hbe);
        reg_wr(OFS_PTR_SELECT, 8'h01);
        run_op(1'b1, 1'b1, 1'b0, 3'h0, 8'h00);
        cmp_val(got_addr, 16'hbeef, "pointer one address");
        cmp_val({8'h00, got_data}, {8'h00, 8'hbe ^ 8'hef ^ 8'h5a}, "pointer one data");
        reg_wr(OFS_PTR_SELECT, 8'h00);
        run_op(1'b1, 1'b1, 1'b0, 3'h0, 8'h00);
        cmp_val(got_addr, 16'h1234, "pointer after decrement");
    endtask : t_select

    task automatic t_index();
        @(posedge i_clk);
        {i_index_reg, i_port2_latch} <= {8'hc3, 8'h7e};
        run_op(1'b1, 1'b0, 1'b1, 3'h0, 8'h3c);
        cmp_val(got_addr, 16'h7ec3, "index write address");
        run_op(1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
        cmp_val({8'h00, got_data}, 16'h003c, "index read back");
    endtask : t_index

    always @(posedge i_clk) begin
        n_cycle++;
        if (n_cycle == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        i_resetn = 1'b0;
        {i_addr, i_wdata, i_wr, i_rd, i_index_reg, i_port2_latch} = '0;
        {i_op_valid, i_op_external_data_move, i_op_ptr_form, i_op_write, i_op_cycles, i_op_wdata} = '0;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_stretch();
        t_normal();
        t_select();
        t_index();
        conclude();
    end
endmodule : test_ext_data_access_stretch
